// ### core/adcc_top.sv
`timescale 1ns/1ns
// conversion control with apb register access
module adcc_top
    import adcc_pkg::*;
#(
    parameter int CYCLES = CONV_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        hw_trigger_input,
    input  wire logic        compare_true,
    input  wire logic [7:0]  conv_result,
    output logic      [4:0]  channel_select,
    output logic             converter_on,
    output logic             sample_start,
    output logic             done_irq,
    output logic             irq
);
    logic [7:0]  ctrl_r;
    logic [7:0]  ctrl_nxt;
    logic [1:0]  cfg_r;
    logic [1:0]  cfg_nxt;
    logic [7:0]  result_r;
    logic [7:0]  result_nxt;
    logic [1:0]  stat_r;
    logic [1:0]  stat_nxt;
    logic [1:0]  mask_r;
    logic [1:0]  mask_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic        pready_r;
    logic        pready_nxt;
    logic        pslverr_r;
    logic        pslverr_nxt;
    logic        done_irq_r;
    logic        irq_r;
    logic        convOn_r;
    logic        convOn_nxt;
    logic        start_r;
    logic        trigPrev_r;
    logic        wrCtrl;
    logic        rdResult;
    logic        access;
    logic        commit;
    logic        hwEdge;
    logic        startReq;
    logic        abortReq;
    logic        busy;
    logic        convDone;
    logic        chanOff;
    logic        flagSet;

    // first access cycle prepares the answer; side effects wait for the ready edge
    assign access   = psel && penable && !pready_r;
    assign commit   = psel && penable && pready_r;
    assign wrCtrl   = commit && pwrite && paddr == OFS_CTRL;
    assign rdResult = commit && !pwrite && paddr == OFS_RESULT;
    assign hwEdge   = hw_trigger_input && !trigPrev_r;
    assign chanOff  = ctrl_nxt[4:0] == CH_OFF;

    // start sources; continuous mode rearms itself at every done that no control write meets
    always_comb begin
        abortReq = wrCtrl;
        startReq = 1'b0;
        if (!chanOff) begin
            if (cfg_r[BIT_TRGSEL] == 1'b0) begin
                startReq = wrCtrl;
            end else begin
                startReq = hwEdge && !busy && !convOn_r;
            end
            if (convDone && ctrl_r[BIT_CONT] && !wrCtrl) begin
                startReq = 1'b1;
            end
        end
    end

    // done flag gating by compare enable
    assign flagSet = convDone && (!cfg_r[BIT_CMPEN] || compare_true);

    // register next state; hardware set of sticky bits beats a clear
    always_comb begin
        ctrl_nxt    = ctrl_r;
        cfg_nxt     = cfg_r;
        mask_nxt    = mask_r;
        stat_nxt    = stat_r;
        result_nxt  = result_r;
        prdata_nxt  = prdata_r;
        pslverr_nxt = 1'b0;
        pready_nxt  = access;
        convOn_nxt  = convOn_r;
        if (access && pwrite) begin
            if (paddr != OFS_CTRL && paddr != OFS_CFG && paddr != OFS_RESULT
                    && paddr != OFS_IRQ_STAT && paddr != OFS_IRQ_MASK) begin
                pslverr_nxt = 1'b1;
            end
        end else if (access) begin
            if (paddr == OFS_CTRL) begin
                prdata_nxt = {24'h0, ctrl_r};
            end else if (paddr == OFS_CFG) begin
                prdata_nxt = {29'h0, busy, cfg_r};
            end else if (paddr == OFS_RESULT) begin
                prdata_nxt = {24'h0, result_r};
            end else if (paddr == OFS_IRQ_STAT) begin
                prdata_nxt = {30'h0, stat_r};
            end else if (paddr == OFS_IRQ_MASK) begin
                prdata_nxt = {30'h0, mask_r};
            end else begin
                prdata_nxt  = 32'h0;
                pslverr_nxt = 1'b1;
            end
        end
        // writes and the read clear land only at the edge where ready is high
        if (commit && pwrite) begin
            if (paddr == OFS_CTRL) begin
                ctrl_nxt = {1'b0, pwdata[6:0]};
            end else if (paddr == OFS_CFG) begin
                cfg_nxt = pwdata[1:0];
            end else if (paddr == OFS_IRQ_STAT) begin
                stat_nxt = stat_r & ~pwdata[1:0];
            end else if (paddr == OFS_IRQ_MASK) begin
                mask_nxt = pwdata[1:0];
            end
        end else if (rdResult) begin
            ctrl_nxt[BIT_DONE] = 1'b0;
        end
        if (flagSet && !wrCtrl) begin
            ctrl_nxt[BIT_DONE] = 1'b1;
            result_nxt = conv_result; // reserved codes give undefined data
            stat_nxt[0] = 1'b1;
        end
        if (flagSet && rdResult) begin
            ctrl_nxt[BIT_DONE] = 1'b1; // set wins over the read clear
        end
        if (hwEdge && cfg_r[BIT_TRGSEL]) begin
            stat_nxt[1] = 1'b1;
        end
        // power follows activity: off after a single conversion or on a control write that starts nothing
        if (startReq) begin
            convOn_nxt = 1'b1;
        end else if (wrCtrl || (convDone && !ctrl_r[BIT_CONT])) begin
            convOn_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r     <= CTRL_RESET;
            cfg_r      <= 2'h0;
            mask_r     <= 2'h0;
            stat_r     <= 2'h0;
            result_r   <= 8'h00;
            prdata_r   <= 32'h0;
            pready_r   <= 1'b0;
            pslverr_r  <= 1'b0;
            convOn_r   <= 1'b0;
            start_r    <= 1'b0;
            trigPrev_r <= 1'b0;
            done_irq_r <= 1'b0;
            irq_r      <= 1'b0;
        end else begin
            ctrl_r     <= ctrl_nxt;
            cfg_r      <= cfg_nxt;
            mask_r     <= mask_nxt;
            stat_r     <= stat_nxt;
            result_r   <= result_nxt;
            prdata_r   <= prdata_nxt;
            pready_r   <= pready_nxt;
            pslverr_r  <= pslverr_nxt;
            convOn_r   <= convOn_nxt;
            start_r    <= startReq;
            trigPrev_r <= hw_trigger_input;
            done_irq_r <= ctrl_nxt[BIT_DONE] && ctrl_nxt[BIT_IEN];
            irq_r      <= |(stat_nxt & mask_nxt);
        end
    end

    // conversion timing; the datapath itself is outside this block
    adcc_conv_timer #(
        .CYCLES (CYCLES)
    ) u_timer (
        .clk   (clk),
        .nrst  (nrst),
        .start (startReq),
        .abort (abortReq),
        .busy  (busy),
        .done  (convDone)
    );

    assign prdata         = prdata_r;
    assign pready         = pready_r;
    assign pslverr        = pslverr_r;
    assign channel_select = ctrl_r[4:0];
    assign converter_on   = convOn_r;
    assign sample_start   = start_r;
    assign done_irq       = done_irq_r;
    assign irq            = irq_r;
endmodule

// ### pkg/adcc_pkg.sv
// How it works
// - any control register write aborts conversion, restarts in software trigger mode unless channel is all ones
// - compare off: done flag bit 7 sets at every conversion end
// - compare on: done flag sets only when compare condition is true
// - done flag clears on control write and on low result byte read
// - done flag set with enable bit 6 high raises completion interrupt
// - continuous bit 5 low: one conversion per start event
// - continuous bit high: repeated conversions after the start event
// - channel field bits 4:0 picks input, high or low reference
// - all-ones channel turns converter off and isolates the input
// - all-ones write stops continuous conversions at once, no extra conversion
// - single mode drops converter to low power after a conversion completes
// - up to 28 analog inputs, chosen by the channel field
// - trigger select picks software write or hardware trigger start
// - compare enable bit gates whether completion sets the done flag
// - reserved channel code still converts, value undefined
package adcc_pkg;
    localparam logic [11:0] OFS_CTRL     = 12'h000; // status/control
    localparam logic [11:0] OFS_CFG      = 12'h004; // trigger select, compare enable
    localparam logic [11:0] OFS_RESULT   = 12'h008; // low result byte (read clears flag)
    localparam logic [11:0] OFS_IRQ_STAT = 12'h00c; // sticky events, write one to clear
    localparam logic [11:0] OFS_IRQ_MASK = 12'h010;
    localparam int          BIT_DONE     = 7;
    localparam int          BIT_IEN      = 6;
    localparam int          BIT_CONT     = 5;
    localparam int          BIT_TRGSEL   = 0;
    localparam int          BIT_CMPEN    = 1;
    localparam int          BIT_ACTIVE   = 2;
    localparam logic [4:0]  CH_LAST_IN   = 5'h1b;
    localparam logic [4:0]  CH_RESERVED  = 5'h1c;
    localparam logic [4:0]  CH_REF_HIGH  = 5'h1d;
    localparam logic [4:0]  CH_REF_LOW   = 5'h1e;
    localparam logic [4:0]  CH_OFF       = 5'h1f;
    localparam logic [7:0]  CTRL_RESET   = 8'h1f; // disabled out of reset
    localparam int          NUM_INPUTS   = 28;
    localparam int          CONV_CYCLES  = 16;
endpackage

// ### core/adcc_conv_timer.sv
`timescale 1ns/1ns
// conversion sequencer stand-in: counts a conversion and pulses done
module adcc_conv_timer
    import adcc_pkg::*;
#(
    parameter int CYCLES = CONV_CYCLES
) (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic start,
    input  wire logic abort,
    output logic      busy,
    output logic      done
);
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic       busy_r;
    logic       busy_nxt;
    logic       done_r;
    logic       done_nxt;

    // abort wins over the end of count so an aborted conversion never completes
    always_comb begin
        cnt_nxt  = cnt_r;
        busy_nxt = busy_r;
        done_nxt = 1'b0;
        if (start) begin
            cnt_nxt  = 8'h00;
            busy_nxt = 1'b1;
        end else if (abort) begin
            busy_nxt = 1'b0;
        end else if (busy_r) begin
            if (cnt_r == 8'(CYCLES - 1)) begin
                busy_nxt = 1'b0;
                done_nxt = 1'b1;
            end else begin
                cnt_nxt = cnt_r + 8'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r  <= 8'h00;
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            cnt_r  <= cnt_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
        end
    end

    assign busy = busy_r;
    assign done = done_r;
endmodule

// ### tb/adcc_props.sv
`timescale 1ns/1ns
// apb handshake and conversion control relations seen at the top ports
module adcc_props
    import adcc_pkg::*;
(
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [4:0]  channel_select,
    input wire logic        converter_on,
    input wire logic        sample_start,
    input wire logic        done_irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // completed accesses decoded once to keep the properties short
    wire acc    = psel && penable && pready;
    wire ctrlWr = acc && pwrite && paddr == OFS_CTRL;
    wire resRd  = acc && !pwrite && paddr == OFS_RESULT;
    pready_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("no answer after one wait state");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held beyond one cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    chan_follow_a: assert property (ctrlWr |=> channel_select == $past(pwdata[4:0]))
        else $error("channel field not taken");
    off_nostart_a: assert property (sample_start |-> channel_select != CH_OFF)
        else $error("start with converter disabled");
    stop_quiet_a: assert property (ctrlWr && pwdata[4:0] == CH_OFF |-> ##2 (!sample_start && !converter_on)[*4])
        else $error("conversion after disable write");
    wr_clear_a: assert property (ctrlWr |-> ##2 !done_irq)
        else $error("flag kept after control write");
    rd_clear_a: assert property (resRd && !converter_on |-> ##2 !done_irq)
        else $error("flag kept after result read");
    cover property (ctrlWr && pwdata[4:0] == CH_OFF);
    cover property (done_irq);
    cover property (pslverr);
endmodule

bind adcc_top adcc_props props (.*);

// ### tb/tb_adc_conversion_control.sv
`timescale 1ns/1ns
// drives the block over apb and checks the control outputs
module tb_adc_conversion_control;
    import adcc_pkg::*;
    localparam int CYC = 4; // short conversion keeps the run brief
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin fail_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, s); end end
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, converter_on, sample_start, done_irq, irq;
    logic        hw_trigger_input = 1'b0, compare_true = 1'b0;
    logic [7:0]  conv_result = 8'h5a;
    logic [4:0]  channel_select;
    int          fail_count = 0, check_count = 0, starts = 0, s0;
    // written byte, expected channel field, expected power
    logic [13:0] rows [6] = '{{8'h00, 5'h00, 1'b1}, {8'h1b, 5'h1b, 1'b1},
        {8'h1c, 5'h1c, 1'b1}, {8'h1d, 5'h1d, 1'b1}, {8'h1e, 5'h1e, 1'b1}, {8'h1f, 5'h1f, 1'b0}};
    adcc_top #(.CYCLES(CYC)) dut (.*);
    // 50 mhz clock
    initial begin
        forever #10 clk = ~clk;
    end
    // start pulses counted for the hardware trigger, continuous and stop checks
    always @(negedge clk) begin
        if (sample_start === 1'b1) starts++;
    end
    task automatic end_of_test();
        $display("mismatches %0d checks %0d", fail_count, check_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // one apb transfer; the request stands until ready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) fail_count++;
        rd = prdata;
        err = pslverr;
        @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // main sequence: table loop first, then the awkward cases
    initial begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        `CHK("reset channel", 5'h1f, channel_select)
        apb(1'b0, OFS_CTRL, 32'h0);
        `CHK("reset ctrl", 32'h1f, rd)
        apb(1'b1, OFS_IRQ_MASK, 32'h1);
        for (int i = 0; i < 6; i++) begin
            apb(1'b1, OFS_CTRL, {24'h0, rows[i][13:6]});
            repeat (2) @(negedge clk);
            `CHK("channel", rows[i][5:1], channel_select)
            `CHK("power", rows[i][0], converter_on)
            repeat (CYC + 4) @(posedge clk);
            `CHK("single idle", 1'b0, converter_on)
            apb(1'b0, OFS_CTRL, 32'h0);
            `CHK("flag", {24'h0, rows[i][0], 2'b00, rows[i][5:1]}, rd)
        end
        `CHK("irq", 1'b1, irq)
        apb(1'b1, OFS_IRQ_STAT, 32'h3);
        apb(1'b1, OFS_IRQ_MASK, 32'h0);
        apb(1'b1, OFS_CTRL, 32'h43);
        repeat (CYC + 4) @(posedge clk);
        `CHK("done irq", 1'b1, done_irq)
        `CHK("masked", 1'b0, irq)
        apb(1'b0, OFS_RESULT, 32'h0);
        `CHK("result", 32'h5a, rd)
        repeat (2) @(negedge clk);
        `CHK("read clear", 1'b0, done_irq)
        // compare gating, false then true
        apb(1'b1, OFS_CFG, 32'h2);
        for (int k = 0; k < 2; k++) begin
            compare_true <= k[0];
            apb(1'b1, OFS_CTRL, 32'h03);
            repeat (CYC + 4) @(posedge clk);
            apb(1'b0, OFS_CTRL, 32'h0);
            `CHK("compare flag", {24'h0, k[0], 7'h03}, rd)
        end
        // hardware trigger: the write alone starts nothing, a held level starts once
        apb(1'b1, OFS_CFG, 32'h1);
        apb(1'b1, OFS_CTRL, 32'h04);
        repeat (CYC + 4) @(posedge clk);
        apb(1'b0, OFS_CTRL, 32'h0);
        `CHK("hw idle", 32'h04, rd)
        s0 = starts;
        hw_trigger_input <= 1'b1;
        repeat (3 * CYC + 8) @(posedge clk);
        hw_trigger_input <= 1'b0;
        `CHK("one start", 1, starts - s0)
        // continuous run, then stop with the all-ones code
        apb(1'b1, OFS_CFG, 32'h0);
        s0 = starts;
        apb(1'b1, OFS_CTRL, 32'h25);
        repeat (3 * CYC + 8) @(posedge clk);
        `CHK("repeat", 1'b1, (starts - s0) >= 3)
        apb(1'b1, OFS_CTRL, 32'h3f);
        repeat (2) @(negedge clk);
        s0 = starts;
        repeat (3 * CYC) @(posedge clk);
        `CHK("stop", 0, starts - s0)
        `CHK("stopped", 1'b0, converter_on)
        apb(1'b0, 12'h020, 32'h0);
        `CHK("slverr", 1'b1, err)
        `CHK("unmapped", 32'h0, rd)
        end_of_test();
    end
    // watchdog cuts a hang short
    initial begin
        repeat (5000) @(posedge clk);
        fail_count++;
        end_of_test();
    end
endmodule
